// ### core/root_hub_regs.sv
// Root hub descriptor register bank with power and overcurrent steering.
// Assumes a same-clock master issuing one-cycle read or write strobes.
`timescale 1ns/1ps
`default_nettype none
module root_hub_regs
    import root_hub_pkg::*;
#(
    parameter logic [1:0] NUM_PORTS = RST_NPORTS
) (
    // Clock and reset.
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    // Register port.
    input  wire root_hub_pkg::reg_req_t req_in,
    output logic [31:0]                rdata_out,
    // Controller state and port power commands.
    input  wire logic                  operational_in,
    input  wire logic                  global_on_in,
    input  wire logic                  global_off_in,
    input  wire logic [2:0]            port_on_in,
    input  wire logic [2:0]            port_off_in,
    // Port power and overcurrent routing.
    output logic [2:0]                 port_power_out,
    output logic                       oc_per_port_out,
    output logic                       oc_global_out,
    output logic [7:0]                 pgood_delay_out,
    output logic [31:0]                pgood_cycles_out
);
    import root_hub_pkg::*;

    logic [7:0] pgood_reg;
    logic       no_overcurrent_protect_reg;
    logic       ocmode_reg;
    logic       noswitch_reg;
    logic       swmode_reg;
    logic [2:0] pmask_reg;
    logic [15:0] hub_status_reg;
    logic [31:0] desc_a;
    logic [31:0] desc_b;
    logic [31:0] rdata_next;
    logic [1:0]  nports;

    // The port count is clamped to two ports.
    // A larger parameter would report ports that have no power pins behind them.
    assign nports = (NUM_PORTS > 2'h2) ? 2'h2 : NUM_PORTS;

    // First descriptor image; reserved and compound bits read zero.
    // Building the image in one place keeps reads and assertions on one definition.
    always_comb begin
        desc_a = 32'h0000_0000;
        desc_a[POS_PGOOD_LO +: 8] = pgood_reg;
        desc_a[POS_NO_OVERCURRENT_PROTECT]     = no_overcurrent_protect_reg;
        desc_a[POS_OCMODE]   = ocmode_reg;
        desc_a[POS_COMPOUND] = 1'b0;
        desc_a[POS_NOSWITCH] = noswitch_reg;
        desc_a[POS_SWMODE]   = swmode_reg;
        desc_a[1:0]          = nports;
    end

    // Second descriptor image holds only the mask here; bit 0 is reserved.
    always_comb begin
        desc_b = 32'h0000_0000;
        desc_b[POS_PMASK_LO +: 3] = {pmask_reg[2:1], 1'b0};
    end

    // First descriptor writes, accepted in any state, whole word only.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pgood_reg    <= RST_PGOOD;
            no_overcurrent_protect_reg     <= RST_NO_OVERCURRENT_PROTECT;
            ocmode_reg   <= RST_SWMODE;
            noswitch_reg <= RST_NOSWITCH;
            swmode_reg   <= RST_SWMODE;
        end else if (req_in.wr && req_in.addr == CODE_DESC_A_WR) begin
            pgood_reg    <= req_in.wdata[POS_PGOOD_LO +: 8];
            no_overcurrent_protect_reg     <= req_in.wdata[POS_NO_OVERCURRENT_PROTECT];
            ocmode_reg   <= req_in.wdata[POS_OCMODE];
            noswitch_reg <= req_in.wdata[POS_NOSWITCH];
            swmode_reg   <= req_in.wdata[POS_SWMODE];
        end
    end

    // Second descriptor mask writes, accepted in any state.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pmask_reg <= RST_PMASK;
        end else if (req_in.wr && req_in.addr == CODE_DESC_B_WR) begin
            pmask_reg <= {req_in.wdata[POS_PMASK_LO + 2], req_in.wdata[POS_PMASK_LO + 1],
                          1'b0};
        end
    end

    // Hub status word store, writable only while operational.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hub_status_reg <= 16'h0000;
        end else if (req_in.wr && req_in.addr == CODE_STATUS_WR && operational_in) begin
            hub_status_reg <= req_in.wdata[15:0];
        end
    end

    // Read mux; unmapped codes return zero.
    always_comb begin
        case (req_in.addr)
            CODE_DESC_A_RD: rdata_next = desc_a;
            CODE_DESC_B_RD: rdata_next = desc_b;
            CODE_STATUS_RD: rdata_next = {16'h0000, hub_status_reg};
            default:        rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data stands for the single cycle after the strobe.
    // Zero between reads lets a master spot a missing strobe at once.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= req_in.rd ? rdata_next : 32'h0000_0000;
        end
    end

    // Port power: always on, ganged, or masked per-port/global split.
    // Ports above the count stay off so a narrow build never powers a dead pin.
    // On wins over off when both commands arrive in one cycle.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            port_power_out <= 3'h0;
        end else begin
            for (int p = 1; p < 3; p++) begin
                if (p > int'(nports)) begin
                    port_power_out[p] <= 1'b0;
                end else if (noswitch_reg) begin
                    port_power_out[p] <= 1'b1;
                end else if (swmode_reg && pmask_reg[p]) begin
                    if (port_on_in[p]) begin
                        port_power_out[p] <= 1'b1;
                    end else if (port_off_in[p]) begin
                        port_power_out[p] <= 1'b0;
                    end
                end else begin
                    if (global_on_in) begin
                        port_power_out[p] <= 1'b1;
                    end else if (global_off_in) begin
                        port_power_out[p] <= 1'b0;
                    end
                end
            end
            port_power_out[0] <= 1'b0;
        end
    end

    // Overcurrent reporting mode decode.
    // Both outputs fall when protection is absent, so neither path reports.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            oc_per_port_out <= 1'b0;
            oc_global_out   <= 1'b0;
        end else begin
            oc_per_port_out <= !no_overcurrent_protect_reg && ocmode_reg;
            oc_global_out   <= !no_overcurrent_protect_reg && !ocmode_reg;
        end
    end

    // Power-good delay and its wait in clock cycles.
    // The product is formed here so the waiting side needs no multiplier.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pgood_delay_out  <= 8'h00;
            pgood_cycles_out <= 32'h0000_0000;
        end else begin
            pgood_delay_out  <= pgood_reg;
            pgood_cycles_out <= 32'(pgood_reg) * 32'(PGOOD_UNIT_CYC);
        end
    end

    // Compound flag never reads one.
    AST_COMPOUND_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
        req_in.rd && req_in.addr == CODE_DESC_A_RD |=> !rdata_out[POS_COMPOUND])
        else $error("Compound flag read as one.");

    // Reserved bits of the first descriptor read as zero.
    AST_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
        req_in.rd && req_in.addr == CODE_DESC_A_RD |=> rdata_out[23:13] == 11'h000
            && rdata_out[7:2] == 6'h00)
        else $error("Reserved bits read nonzero.");

    // Port count never above two.
    AST_PORTS_MAX: assert property (@(posedge clk_in) disable iff (reset_in)
        req_in.rd && req_in.addr == CODE_DESC_A_RD |=> rdata_out[1:0] <= 2'h2)
        else $error("Port count above two.");

    // Write to first descriptor loads the written delay into the field register.
    sequence s_write_a;
        req_in.wr && req_in.addr == CODE_DESC_A_WR;
    endsequence
    AST_PGOOD_WRITE: assert property (@(posedge clk_in) disable iff (reset_in)
        s_write_a |=> pgood_reg == $past(req_in.wdata[31:24]))
        else $error("Delay field did not take the write.");

    // Always-powered ports are on in the next cycle.
    AST_ALWAYS_ON: assert property (@(posedge clk_in) disable iff (reset_in)
        noswitch_reg && nports == 2'h2 |=> port_power_out[2:1] == 2'b11)
        else $error("Always-powered port is off.");

    // Masked ports ignore global commands in individual mode.
    AST_MASK_GLOBAL: assert property (@(posedge clk_in) disable iff (reset_in)
        !noswitch_reg && swmode_reg && pmask_reg[1] && !port_on_in[1] && !port_off_in[1]
            |=> $stable(port_power_out[1]))
        else $error("Masked port followed a global command.");

    // Status writes outside the operational state leave it unchanged.
    AST_STATUS_GUARD: assert property (@(posedge clk_in) disable iff (reset_in)
        req_in.wr && req_in.addr == CODE_STATUS_WR && !operational_in
            |=> $stable(hub_status_reg))
        else $error("Status took a write outside operational state.");

    // No overcurrent protection disables both reporting outputs.
    AST_NO_OVERCURRENT_PROTECT_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
        no_overcurrent_protect_reg |=> !oc_per_port_out && !oc_global_out)
        else $error("Overcurrent reported while unsupported.");

    // Read data only stands in the cycle after a read strobe.
    AST_READ_IDLE: assert property (@(posedge clk_in) disable iff (reset_in)
        !req_in.rd |=> rdata_out == 32'h0000_0000)
        else $error("Read data without a read strobe.");

    // Sequences shared by the bus properties below.
    sequence s_write_b;
        req_in.wr && req_in.addr == CODE_DESC_B_WR;
    endsequence
    sequence s_write_status;
        req_in.wr && req_in.addr == CODE_STATUS_WR;
    endsequence
    sequence s_read_a;
        req_in.rd && req_in.addr == CODE_DESC_A_RD;
    endsequence
    sequence s_read_b;
        req_in.rd && req_in.addr == CODE_DESC_B_RD;
    endsequence

    // A first descriptor read returns the live register image next cycle.
    AST_READ_A: assert property (@(posedge clk_in) disable iff (reset_in)
        s_read_a |=> rdata_out == $past(desc_a))
        else $error("First descriptor read returned a stale word.");

    // Second descriptor reads show only the two mask bits.
    AST_READ_B: assert property (@(posedge clk_in) disable iff (reset_in)
        s_read_b |=> rdata_out[31:19] == 13'h0000 && rdata_out[16:0] == 17'h00000
            && rdata_out[18:17] == $past(pmask_reg[2:1]))
        else $error("Second descriptor read returned a wrong word.");

    // Switch and overcurrent fields take a first descriptor write.
    AST_FIELDS_WRITE: assert property (@(posedge clk_in) disable iff (reset_in)
        s_write_a |=> no_overcurrent_protect_reg == $past(req_in.wdata[12]) && ocmode_reg == $past(req_in.wdata[11])
            && noswitch_reg == $past(req_in.wdata[9]) && swmode_reg == $past(req_in.wdata[8]))
        else $error("Switch or overcurrent field did not take the write.");

    // Mask writes land whatever the controller state.
    AST_MASK_WRITE: assert property (@(posedge clk_in) disable iff (reset_in)
        s_write_b |=> pmask_reg[2:1] == $past(req_in.wdata[18:17]))
        else $error("Mask field did not take the write.");

    // Status writes land while the controller is operational.
    AST_STATUS_WRITE: assert property (@(posedge clk_in) disable iff (reset_in)
        s_write_status ##0 operational_in |=> hub_status_reg == $past(req_in.wdata[15:0]))
        else $error("Status did not take an operational write.");

    // Status reads return the stored half word with a clear upper half.
    AST_STATUS_READ: assert property (@(posedge clk_in) disable iff (reset_in)
        req_in.rd && req_in.addr == CODE_STATUS_RD
            |=> rdata_out == {16'h0000, $past(hub_status_reg)})
        else $error("Status read returned a wrong word.");

    // Overcurrent mode comes out of reset equal to the switching mode.
    AST_OCMODE_RESET: assert property (@(posedge clk_in) disable iff (reset_in)
        $past(reset_in) |-> ocmode_reg == swmode_reg)
        else $error("Overcurrent mode differs from switching mode after reset.");

    // Collective reporting when protection exists and the mode bit is clear.
    AST_OC_GLOBAL: assert property (@(posedge clk_in) disable iff (reset_in)
        !no_overcurrent_protect_reg && !ocmode_reg |=> oc_global_out && !oc_per_port_out)
        else $error("Collective overcurrent reporting not selected.");

    // Per-port reporting when protection exists and the mode bit is set.
    AST_OC_PER_PORT: assert property (@(posedge clk_in) disable iff (reset_in)
        !no_overcurrent_protect_reg && ocmode_reg |=> oc_per_port_out && !oc_global_out)
        else $error("Per-port overcurrent reporting not selected.");

    // Delay copy and its cycle count follow the field one cycle later.
    AST_DELAY_COPY: assert property (@(posedge clk_in) disable iff (reset_in)
        !$past(reset_in) |-> pgood_delay_out == $past(pgood_reg)
            && pgood_cycles_out == 32'($past(pgood_reg)) * 32'(PGOOD_UNIT_CYC))
        else $error("Delay outputs do not follow the field.");

    // Ganged mode: a global on powers both ports together.
    AST_GANGED_ON: assert property (@(posedge clk_in) disable iff (reset_in)
        !noswitch_reg && !swmode_reg && global_on_in && nports == 2'h2
            |=> port_power_out[2:1] == 2'b11)
        else $error("Ganged on did not power both ports.");

    // Ganged mode: a global off alone removes power from both ports.
    AST_GANGED_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
        !noswitch_reg && !swmode_reg && global_off_in && !global_on_in && nports == 2'h2
            |=> port_power_out[2:1] == 2'b00)
        else $error("Ganged off left a port powered.");

    // Masked ports obey their own on command in individual mode.
    AST_PORT_ON: assert property (@(posedge clk_in) disable iff (reset_in)
        !noswitch_reg && swmode_reg && pmask_reg[1] && port_on_in[1] |=> port_power_out[1])
        else $error("Masked port ignored its on command.");

    // Masked ports obey their own off command in individual mode.
    AST_PORT_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
        !noswitch_reg && swmode_reg && pmask_reg[1] && port_off_in[1] && !port_on_in[1]
            |=> !port_power_out[1])
        else $error("Masked port ignored its off command.");

    // The second port, when masked, also ignores global commands.
    AST_MASK_GLOBAL_TWO: assert property (@(posedge clk_in) disable iff (reset_in)
        !noswitch_reg && swmode_reg && pmask_reg[2] && !port_on_in[2] && !port_off_in[2]
            |=> $stable(port_power_out[2]))
        else $error("Masked second port followed a global command.");

    // Unmasked ports ignore per-port commands in individual mode.
    AST_UNMASKED_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
        !noswitch_reg && swmode_reg && !pmask_reg[2] && !global_on_in && !global_off_in
            |=> $stable(port_power_out[2]))
        else $error("Unmasked port followed a per-port command.");

endmodule
`default_nettype wire

// ### include/root_hub_pkg.sv
// Constants and carrier types for the root hub descriptor register bank.
// Assumes a 32-bit command-code register port on a single clock.
package root_hub_pkg;

    // Command codes: read code, write code is read code with bit 7 set.
    localparam logic [7:0] CODE_DESC_A_RD   = 8'h12;
    localparam logic [7:0] CODE_DESC_A_WR   = 8'h92;
    localparam logic [7:0] CODE_DESC_B_RD   = 8'h13;
    localparam logic [7:0] CODE_DESC_B_WR   = 8'h93;
    localparam logic [7:0] CODE_STATUS_RD   = 8'h14;
    localparam logic [7:0] CODE_STATUS_WR   = 8'h94;

    // Field positions in the first descriptor register; the mask start is in the second.
    localparam int POS_PGOOD_LO  = 24;
    localparam int POS_NO_OVERCURRENT_PROTECT      = 12;
    localparam int POS_OCMODE    = 11;
    localparam int POS_COMPOUND  = 10;
    localparam int POS_NOSWITCH  = 9;
    localparam int POS_SWMODE    = 8;
    localparam int POS_PMASK_LO  = 16;

    // Reset values of the implementation-specific fields.
    localparam logic [7:0] RST_PGOOD    = 8'h01;
    localparam logic       RST_NO_OVERCURRENT_PROTECT     = 1'b0;
    localparam logic       RST_NOSWITCH = 1'b0;
    localparam logic       RST_SWMODE   = 1'b1;
    localparam logic [1:0] RST_NPORTS   = 2'h2;
    localparam logic [2:0] RST_PMASK    = 3'h0;

    // Power-good unit time and its cycle count at 10 MHz.
    localparam int PGOOD_UNIT_NS = 2000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PGOOD_UNIT_CYC = PGOOD_UNIT_NS / CLK_PERIOD_NS;

    // Register bus request carrier.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Port power effects, one bit per port (bit 0 unused).
    typedef struct packed {
        logic [2:0] per_port;
        logic [2:0] ganged;
    } power_route_t;

endpackage

// ### verification/root_hub_regs_tb.sv
// Self-checking testbench for the root hub descriptor register bank.
// Assumes the bank is driven straight from its ports with no partner model.
`timescale 1ns/1ps
`default_nettype none
module root_hub_regs_tb;
    import root_hub_pkg::*;

    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    reg_req_t    req = '0;
    logic        op = 1'b0;
    logic        gon = 1'b0;
    logic        goff = 1'b0;
    logic [2:0]  pon = 3'h0;
    logic [2:0]  poff = 3'h0;
    logic [31:0] rdata;
    logic [2:0]  power;
    logic        oc_pp;
    logic        oc_gl;
    logic [7:0]  pg_delay;
    logic [31:0] pg_cyc;
    logic [31:0] d;
    int          num_errors = 0;
    int          checks = 0;

    // Free-running 100 ns clock.
    always #50 clk_in = ~clk_in;

    root_hub_regs #(.NUM_PORTS(2'h2)) dut_u (
        .clk_in(clk_in), .reset_in(reset_in), .req_in(req), .rdata_out(rdata),
        .operational_in(op), .global_on_in(gon), .global_off_in(goff),
        .port_on_in(pon), .port_off_in(poff), .port_power_out(power),
        .oc_per_port_out(oc_pp), .oc_global_out(oc_gl),
        .pgood_delay_out(pg_delay), .pgood_cycles_out(pg_cyc));

    // Compares one observed value against its expectation.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe, released at the next edge.
    task automatic wr_word(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk_in);
        req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req <= '0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // One-cycle read strobe; data is taken in the following cycle only.
    task automatic rd_word(input logic [7:0] a, output logic [31:0] r);
        @(posedge clk_in);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req <= '0;
        #1 r = rdata;
    endtask

    // Pulses power commands for one cycle and lets the outputs settle.
    task automatic cmd(input logic on, input logic off,
                       input logic [2:0] p1, input logic [2:0] p0);
        @(posedge clk_in);
        {gon, goff, pon, poff} <= {on, off, p1, p0};
        @(posedge clk_in);
        {gon, goff, pon, poff} <= '0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // Reset contents and derived outputs.
    task automatic t_reset();
        rd_word(8'h12, d);
        chk(d, 32'h0100_0902, "reset word");
        chk({oc_pp, oc_gl}, 32'h2, "reset oc routing");
        chk(pg_cyc, 32'd20000, "reset delay cycles");
    endtask

    // All-ones write outside the operational state.
    task automatic t_fields();
        wr_word(8'h92, 32'hFFFF_FFFF);
        rd_word(8'h12, d);
        chk(d, 32'hFF00_1B02, "masked word");
        chk({24'h0, pg_delay}, 32'h0000_00FF, "delay copy");
        chk(pg_cyc, 32'd5100000, "delay cycles");
        chk({oc_pp, oc_gl}, 32'h0, "no oc reporting");
    endtask

    // Overcurrent mode cleared, then set, as at power-up.
    task automatic t_oc();
        wr_word(8'h92, 32'h0000_0000);
        chk({oc_pp, oc_gl}, 32'h1, "collective oc");
        wr_word(8'h92, 32'h0000_0800);
        chk({oc_pp, oc_gl}, 32'h2, "per-port oc");
    endtask

    // Ganged, individual with mask, and always-powered modes.
    task automatic t_power();
        wr_word(8'h92, 32'h0000_0000);
        cmd(1'b1, 1'b0, 3'h0, 3'h0);
        chk(power, 32'h6, "ganged on");
        cmd(1'b0, 1'b1, 3'h0, 3'h0);
        chk(power, 32'h0, "ganged off");
        cmd(1'b1, 1'b1, 3'h0, 3'h0);
        chk(power, 32'h6, "ganged on wins over off");
        cmd(1'b0, 1'b1, 3'h0, 3'h0);
        chk(power, 32'h0, "ganged off again");
        wr_word(8'h92, 32'h0000_0100);
        wr_word(8'h93, 32'h0002_0000);
        rd_word(8'h13, d);
        chk(d, 32'h0002_0000, "mask word");
        cmd(1'b1, 1'b0, 3'h0, 3'h0);
        chk(power, 32'h4, "global skips masked");
        cmd(1'b0, 1'b0, 3'h2, 3'h0);
        chk(power, 32'h6, "port on masked");
        cmd(1'b0, 1'b1, 3'h0, 3'h0);
        chk(power, 32'h2, "global off skips masked");
        cmd(1'b0, 1'b0, 3'h0, 3'h2);
        chk(power, 32'h0, "port off masked");
        wr_word(8'h92, 32'h0000_0200);
        chk(power, 32'h6, "always powered");
    endtask

    // Status write gating and an unmapped code.
    task automatic t_bus();
        @(posedge clk_in);
        op <= 1'b1;
        wr_word(8'h94, 32'h0000_A5A5);
        @(posedge clk_in);
        op <= 1'b0;
        wr_word(8'h94, 32'h0000_1234);
        rd_word(8'h14, d);
        chk(d, 32'h0000_A5A5, "status word");
        wr_word(8'h20, 32'hFFFF_FFFF);
        rd_word(8'h20, d);
        chk(d, 32'h0, "unmapped read");
        @(posedge clk_in);
        #1 chk(rdata, 32'h0, "read data idle");
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        t_reset();
        t_fields();
        t_oc();
        t_power();
        t_bus();
        complete_run();
    end

    // Watchdog well beyond the hundred or so cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
